// ### core/uiq_map.svh
/*
  Constants for the interrupt identification and queue control block:
  register offsets, field positions, reset values and ident codes.
  Assumes inclusion by bare name from the package and the modules.
*/
`ifndef UIQ_MAP_SVH
`define UIQ_MAP_SVH
`define UIQ_OFF_IDENT 4'h0
`define UIQ_OFF_STATUS 4'h4
`define UIQ_OFF_MASK 4'h8
`define UIQ_OFF_SRC 4'hC
`define UIQ_BIT_ENABLE 0
`define UIQ_BIT_RX_RESET 1
`define UIQ_BIT_TX_RESET 2
`define UIQ_ENABLE_RESET 1'h1
`define UIQ_ID_NONE 4'h1
`define UIQ_ID_TX_HOLD_EMPTY 4'h2
`define UIQ_ID_RX_DATA 4'h4
`define UIQ_ID_LINE_STATUS 4'h6
`define UIQ_ID_BUSY 4'h7
`define UIQ_ID_TIMEOUT 4'hC
`define UIQ_EV_TX_RESET 0
`define UIQ_EV_RX_RESET 1
`define UIQ_EV_ENABLE_CHG 2
`define UIQ_EV_WIDTH 3
`define UIQ_RESP_OKAY 2'h0
`define UIQ_RESP_SLVERR 2'h2
`endif

// ### core/uiq_pkg.sv
/*
  Types for the interrupt identification and queue control block.
  Assumes the constants header is on the include path.
*/
package uiq_pkg;
  `include "uiq_map.svh"
  typedef logic [3:0] uiq_ident_type;
  typedef logic [`UIQ_EV_WIDTH-1:0] uiq_event_type;
endpackage : uiq_pkg

// ### core/uiq_prio.sv
/*
  Priority encoder: picks the ident code of the highest-priority
  active source. Assumes source levels are on the block clock.
*/
`timescale 1ns/1ns
`include "uiq_map.svh"
module uiq_prio
  import uiq_pkg::*;
(
  input wire logic line_status,
  input wire logic rx_data,
  input wire logic char_timeout,
  input wire logic tx_holding_register_empty,
  input wire logic busy_detect,
  output uiq_ident_type code
);
  ////////////////////////////////////////////////////////////////////////////
  // Line status first, then receive data and timeout, then transmit empty,
  // then busy detect; nothing active gives the no-pending pattern.
  always_comb begin
    if (line_status) begin
      code = `UIQ_ID_LINE_STATUS;
    end else if (rx_data) begin
      code = `UIQ_ID_RX_DATA;
    end else if (char_timeout) begin
      code = `UIQ_ID_TIMEOUT;
    end else if (tx_holding_register_empty) begin
      code = `UIQ_ID_TX_HOLD_EMPTY;
    end else if (busy_detect) begin
      code = `UIQ_ID_BUSY;
    end else begin
      code = `UIQ_ID_NONE;
    end
  end
endmodule : uiq_prio

// ### core/uiq_top.sv
/*
  Interrupt identification and queue control location behind an
  AXI4-Lite slave. Reads of the shared word return the ident code;
  writes set queue enable and pulse the queue resets. A status, a
  mask and a read-only source view sit beside it for the interrupt
  line. Every output, ready signals included, comes from a flop.
  Assumes the interrupt sources arrive as levels on aclk, already
  synchronous, and that the master keeps one write and one read in
  flight at most.
*/
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "uiq_map.svh"
module uiq_top
  import uiq_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic src_line_status,
  input wire logic src_rx_data,
  input wire logic src_char_timeout,
  input wire logic src_tx_holding_register_empty,
  input wire logic src_busy_detect,
  output logic queue_enable,
  output logic tx_queue_reset,
  output logic rx_queue_reset,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  // Write channel state.
  logic aw_held_q, aw_held_d;
  logic [3:0] aw_addr_q, aw_addr_d;
  logic w_held_q, w_held_d;
  logic [31:0] w_data_q, w_data_d;
  logic [3:0] w_strb_q, w_strb_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  // Read channel state.
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  // Control and interrupt state.
  logic enable_q, enable_d;
  logic tx_rst_q, tx_rst_d;
  logic rx_rst_q, rx_rst_d;
  uiq_event_type status_q, status_d;
  uiq_event_type mask_q, mask_d;
  logic irq_q, irq_d;
  uiq_ident_type ident;
  logic do_write;
  uiq_event_type events;
  logic new_enable;
  logic [4:0] src_vec;
  // Ready flags.
  logic awready_q, awready_d;
  logic wready_q, wready_d;
  logic arready_q, arready_d;

  ////////////////////////////////////////////////////////////////////////////
  // Source priority lives in its own module so the table sits in one place.
  // It is purely combinational; the read data flop registers its code.
  uiq_prio u_prio (
    .line_status(src_line_status),
    .rx_data(src_rx_data),
    .char_timeout(src_char_timeout),
    .tx_holding_register_empty(src_tx_holding_register_empty),
    .busy_detect(src_busy_detect),
    .code(ident)
  );

  assign src_vec = {src_busy_detect, src_tx_holding_register_empty,
                    src_char_timeout, src_rx_data, src_line_status};

  ////////////////////////////////////////////////////////////////////////////
  // A write commits once both address and data are held and no response
  // waits, so only one write is ever in flight.
  // Holding both halves first lets the master offer them in any order.
  assign do_write = aw_held_q && w_held_q && !bvalid_q;

  // Write channel: address and data taken independently, in either order.
  // The response code is fixed at commit time, so bready may lag freely.
  always_comb begin
    aw_held_d = aw_held_q;
    aw_addr_d = aw_addr_q;
    w_held_d = w_held_q;
    w_data_d = w_data_q;
    w_strb_d = w_strb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    if (s_axi_awvalid && !aw_held_q) begin
      aw_held_d = 1'h1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_q) begin
      w_held_d = 1'h1;
      w_data_d = s_axi_wdata;
      w_strb_d = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_d = 1'h0;
      w_held_d = 1'h0;
      bvalid_d = 1'h1;
      case (aw_addr_q)
        `UIQ_OFF_IDENT, `UIQ_OFF_STATUS, `UIQ_OFF_MASK: begin
          bresp_d = `UIQ_RESP_OKAY;
        end
        `UIQ_OFF_SRC: begin
          bresp_d = `UIQ_RESP_SLVERR; // Read-only source view.
        end
        default: begin
          bresp_d = `UIQ_RESP_SLVERR;
        end
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'h0;
    end
  end

  // Write channel registers; the sync reset leaves both halves empty.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'h0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'h0;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'h0;
      bresp_q <= 2'h0;
    end else begin
      aw_held_q <= aw_held_d;
      aw_addr_q <= aw_addr_d;
      w_held_q <= w_held_d;
      w_data_q <= w_data_d;
      w_strb_q <= w_strb_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Queue control. The reset outputs are one-cycle pulses, so software
  // never has to clear them; a change of enable also fires both.
  // A write that keeps enable and sets no reset bit still reloads enable,
  // which is harmless since the value stays the same.
  assign new_enable = w_data_q[`UIQ_BIT_ENABLE];

  always_comb begin
    enable_d = enable_q;
    tx_rst_d = 1'h0;
    rx_rst_d = 1'h0;
    if (do_write && aw_addr_q == `UIQ_OFF_IDENT && w_strb_q[0]) begin
      enable_d = new_enable;
      tx_rst_d = w_data_q[`UIQ_BIT_TX_RESET] ||
                 (new_enable != enable_q);
      rx_rst_d = w_data_q[`UIQ_BIT_RX_RESET] ||
                 (new_enable != enable_q);
    end
  end

  // Enable leaves reset set, so both queues start switched on.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= `UIQ_ENABLE_RESET;
      tx_rst_q <= 1'h0;
      rx_rst_q <= 1'h0;
    end else begin
      enable_q <= enable_d;
      tx_rst_q <= tx_rst_d;
      rx_rst_q <= rx_rst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status: each queue reset and enable change is sticky until
  // written with a one. A new event in the clearing cycle wins the clear.
  // The irq flop looks at next-state status and mask, so it lines up
  // with the status bits instead of lagging them by a cycle.
  assign events = {(enable_d != enable_q), rx_rst_d, tx_rst_d};

  always_comb begin
    status_d = status_q;
    mask_d = mask_q;
    if (do_write && aw_addr_q == `UIQ_OFF_STATUS && w_strb_q[0]) begin
      status_d = status_q & ~w_data_q[`UIQ_EV_WIDTH-1:0];
    end
    if (do_write && aw_addr_q == `UIQ_OFF_MASK && w_strb_q[0]) begin
      mask_d = w_data_q[`UIQ_EV_WIDTH-1:0];
    end
    status_d = status_d | events;
    irq_d = |(status_d & mask_d);
  end

  // Status and mask clear on reset, which keeps irq low after it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= '0;
      mask_q <= '0;
      irq_q <= 1'h0;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel. The ident word is a live view of the sources and no
  // write path reaches it, so writes can never alter what a read shows.
  // The address is decoded as it is taken, so read data reflect the
  // sources in the cycle of the address handshake, not a later one.
  always_comb begin
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (!rvalid_q && s_axi_arvalid) begin
      rvalid_d = 1'h1;
      rresp_d = `UIQ_RESP_OKAY;
      case (s_axi_araddr)
        `UIQ_OFF_IDENT: begin
          rdata_d = {28'h0, ident};
        end
        `UIQ_OFF_STATUS: begin
          rdata_d = {29'h0, status_q};
        end
        `UIQ_OFF_MASK: begin
          rdata_d = {29'h0, mask_q};
        end
        `UIQ_OFF_SRC: begin
          rdata_d = {26'h0, enable_q, src_vec};
        end
        default: begin
          rdata_d = 32'h0;
          rresp_d = `UIQ_RESP_SLVERR;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'h0;
    end
  end

  // Read channel registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'h0;
      rdata_q <= 32'h0;
      rresp_q <= 2'h0;
    end else begin
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready outputs get flops of their own, loaded with the inverse of the
  // next held flags (of the next rvalid for arready), so each port comes
  // straight from a register while still tracking those flags cycle for cycle.
  always_comb begin
    awready_d = !aw_held_d;
    wready_d = !w_held_d;
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'h1;
      wready_q <= 1'h1;
      arready_q <= 1'h1;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      arready_q <= arready_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Every output is a plain copy of a flop, so no logic sits on a port.
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_arready = arready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign queue_enable = enable_q;
  assign tx_queue_reset = tx_rst_q;
  assign rx_queue_reset = rx_rst_q;
  assign irq = irq_q;
endmodule : uiq_top

// ### verif/uiq_top_props.sv
/*
  Checker for uiq_top: ident codes, queue resets and queue enable.
  Assumes it is bound to uiq_top and sees only that module's ports.
*/
`timescale 1ns/1ns
module uiq_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic src_line_status,
  input wire logic src_rx_data,
  input wire logic src_char_timeout,
  input wire logic src_tx_holding_register_empty,
  input wire logic src_busy_detect,
  input wire logic queue_enable,
  input wire logic tx_queue_reset,
  input wire logic rx_queue_reset
);
  logic [3:0] exp_code;
  logic wt;
  logic rt;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  // Only joint address and data takes count, which is how the bench writes.
  assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    && s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
  assign rt = s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'h0;
  // Reference priority, worked out apart from the design's encoder.
  always_comb begin
    if (src_line_status) exp_code = 4'h6;
    else if (src_rx_data) exp_code = 4'h4;
    else if (src_char_timeout) exp_code = 4'hC;
    else if (src_tx_holding_register_empty) exp_code = 4'h2;
    else if (src_busy_detect) exp_code = 4'h7;
    else exp_code = 4'h1;
  end
  property p_ident;
    rt |=> s_axi_rdata == {28'h0, $past(exp_code)};
  endproperty
  a_ident: assert property (p_ident) else $error("ident code wrong");
  property p_none;
    rt && {src_line_status, src_rx_data, src_char_timeout,
      src_tx_holding_register_empty, src_busy_detect} == 5'h0
      |=> s_axi_rdata[3:0] == 4'h1;
  endproperty
  a_none: assert property (p_none) else $error("idle code wrong");
  property p_tx;
    wt && s_axi_wdata[2] |-> ##2 tx_queue_reset ##1 !tx_queue_reset;
  endproperty
  a_tx: assert property (p_tx) else $error("tx reset pulse wrong");
  property p_rx;
    wt && s_axi_wdata[1] |-> ##2 rx_queue_reset ##1 !rx_queue_reset;
  endproperty
  a_rx: assert property (p_rx) else $error("rx reset pulse wrong");
  property p_en;
    wt |-> ##2 queue_enable == $past(s_axi_wdata[0], 2);
  endproperty
  a_en: assert property (p_en) else $error("enable not taken");
  property p_chg;
    $changed(queue_enable) && $past(aresetn)
      |-> tx_queue_reset && rx_queue_reset;
  endproperty
  a_chg: assert property (p_chg) else $error("no reset on change");
  property p_wr;
    wt |-> ##2 s_axi_bvalid && s_axi_bresp == 2'h0;
  endproperty
  a_wr: assert property (p_wr) else $error("control write refused");
endmodule : uiq_props
bind uiq_top uiq_props uiq_props_inst (.*);

// ### verif/test_uart_interrupt_id_fifo_control.sv
/*
  Bench for uiq_top: a table of source levels, then control writes,
  interrupt and error cases. Assumes the slave timing in its note.
*/
`timescale 1ns/1ns
module test_uart_interrupt_id_fifo_control;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, queue_enable, tx_queue_reset, rx_queue_reset, irq;
  logic src_line_status = 1'h0, src_rx_data = 1'h0;
  logic src_tx_holding_register_empty = 1'h0;
  logic src_char_timeout = 1'h0, src_busy_detect = 1'h0;
  int bad_count = 0, checked = 0, txn = 0, rxn = 0;
  // Each row: levels {busy, tx holding, timeout, rx, line}, then the code.
  logic [8:0] rows [7] = '{9'h001, 9'h107, 9'h182, 9'h1CC, 9'h1E4,
    9'h1F6, 9'h0A4};
  uiq_top uiq_top_inst (.*);
  ////////////////////////////////////////
  // Clock at 100 ns period.
  initial forever #50 aclk = ~aclk;
  // Count pulses mid-cycle, away from the edges that move them.
  always @(negedge aclk) begin
    txn += tx_queue_reset;
    rxn += rx_queue_reset;
  end
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] v,
    input logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
    chk(s_axi_bresp, r);
  endtask : wr
  // Read data and response are compared together as one value.
  task automatic rd(input logic [3:0] a, input logic [33:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask : rd
  task automatic print_verdict;
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  // Watchdog well beyond the hundred or so cycles the tests need.
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end
  // Table of sources first, then control writes, interrupt, errors.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    chk(queue_enable, 1'h1);
    foreach (rows[i]) begin
      {src_busy_detect, src_tx_holding_register_empty, src_char_timeout,
        src_rx_data, src_line_status} <= rows[i][8:4];
      rd(4'h0, rows[i][3:0]);
    end
    wr(4'h0, 32'h5, 2'h0);
    chk({txn[3:0], rxn[3:0], queue_enable}, 9'h021);
    rd(4'h0, 34'h4);
    wr(4'h0, 32'h3, 2'h0);
    chk({txn[3:0], rxn[3:0], queue_enable}, 9'h023);
    wr(4'h0, 32'h0, 2'h0);
    wr(4'h0, 32'h0, 2'h0);
    chk({txn[3:0], rxn[3:0], queue_enable}, 9'h044);
    wr(4'h0, 32'h1, 2'h0);
    chk({txn[3:0], rxn[3:0], queue_enable}, 9'h067);
    // A write with byte lane 0 off must leave enable and the resets alone.
    s_axi_wstrb <= 4'h0;
    wr(4'h0, 32'h6, 2'h0);
    s_axi_wstrb <= 4'hF;
    chk({txn[3:0], rxn[3:0], queue_enable}, 9'h067);
    rd(4'h4, 34'h7);
    chk(irq, 1'h0);
    wr(4'h8, 32'h4, 2'h0);
    rd(4'h8, 34'h4);
    chk(irq, 1'h1);
    wr(4'h4, 32'h4, 2'h0);
    rd(4'h4, 34'h3);
    chk(irq, 1'h0);
    wr(4'hC, 32'h0, 2'h2);
    rd(4'hC, 34'h2A);
    wr(4'h2, 32'h0, 2'h2);
    rd(4'h2, 34'h200000000);
    // Reset in mid-run with enable low and every event unmasked.
    wr(4'h8, 32'h7, 2'h0);
    wr(4'h0, 32'h0, 2'h0);
    chk(irq, 1'h1);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    chk({queue_enable, irq, tx_queue_reset, rx_queue_reset}, 4'h8);
    rd(4'h4, 34'h0);
    rd(4'h8, 34'h0);
    rd(4'h0, 34'h4);
    print_verdict();
  end
endmodule : test_uart_interrupt_id_fifo_control
